/* rtl/mbpwm_pkg.sv */
// Constants for the match based PWM timer: offsets, fields, reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte offsets.
//
// Overview of operation
// - A 32-bit counter advances once per terminal count of a 32-bit prescaler.
// - Count source is the clock (timer) or edges of a chosen capture input.
// - Seven match registers feed six outputs, single-edge or, on outputs 2 to 6, double-edge.
// - Cycle match register resets the counter and sets the shared period.
// - Single-edge outputs rise at each cycle match unless held constant low.
// - One extra match register places each single-edge output's falling edge.
// - Double-edge outputs use two match registers for rise and fall positions.
// - Rise before fall gives a positive pulse, fall first a negative one.
// - Period and width are any whole number of counter counts.
// - Software releases new match values; with modulation on they apply only at a cycle boundary.
// - Each match may continue, stop or reset the counter, optionally interrupting.
// - With modulation off the block is a plain timer with match actions.
// - Two units run in lockstep, the leader's enable starting the follower.
// - A capture input edge latches the counter, optionally raising an interrupt.
// - Each external match output goes low, high, toggles or holds on match.
package mbpwm_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int SW = 4;
  localparam int NMATCH = 7;
  localparam int NCAP = 2;
  localparam int NEXT = 4;
  localparam int NPWM = 6;
  // Register byte offsets
  localparam logic [7:0] OFF_IR = 8'h00;
  localparam logic [7:0] OFF_TCR = 8'h04;
  localparam logic [7:0] OFF_TC = 8'h08;
  localparam logic [7:0] OFF_PR = 8'h0c;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_MCR = 8'h14;
  localparam logic [7:0] OFF_MR0 = 8'h18;
  localparam logic [7:0] OFF_MR_LAST = 8'h30;
  localparam logic [7:0] OFF_CCR = 8'h34;
  localparam logic [7:0] OFF_CR0 = 8'h38;
  localparam logic [7:0] OFF_CR1 = 8'h3c;
  localparam logic [7:0] OFF_EMR = 8'h40;
  localparam logic [7:0] OFF_CTCR = 8'h44;
  localparam logic [7:0] OFF_PCR = 8'h48;
  localparam logic [7:0] OFF_LER = 8'h4c;
  localparam logic [7:0] OFF_IMR = 8'h50;
  localparam logic [7:0] OFF_SYNC = 8'h54;
  // Timer control bits
  localparam int TCR_EN = 0;
  localparam int TCR_RST = 1;
  localparam int TCR_PWM = 3;
  localparam int TCR_W = 4;
  // Match control, three bits per match register
  localparam int MCR_INT = 0;
  localparam int MCR_RST = 1;
  localparam int MCR_STOP = 2;
  localparam int MCR_W = 3;
  localparam int MCR_BITS = NMATCH * MCR_W;
  // Capture control, three bits per capture input
  localparam int CCR_RISE = 0;
  localparam int CCR_FALL = 1;
  localparam int CCR_INT = 2;
  localparam int CCR_W = 3;
  localparam int CCR_BITS = NCAP * CCR_W;
  // External match: levels in low bits, two action bits each above
  localparam int EMR_CTL = 4;
  localparam int EMR_W = EMR_CTL + 2 * NEXT;
  localparam logic [1:0] EM_NONE = 2'h0;
  localparam logic [1:0] EM_LOW = 2'h1;
  localparam logic [1:0] EM_HIGH = 2'h2;
  localparam logic [1:0] EM_TOGGLE = 2'h3;
  // Count source select
  localparam int CTCR_SEL = 2;
  localparam int CTCR_W = 3;
  localparam logic [1:0] CNT_TIMER = 2'h0;
  localparam logic [1:0] CNT_RISE = 2'h1;
  localparam logic [1:0] CNT_FALL = 2'h2;
  localparam logic [1:0] CNT_BOTH = 2'h3;
  // Modulator control: double-edge selects at bit n, enables at 8+n
  localparam int PCR_ENA = 8;
  localparam int PCR_W = PCR_ENA + NPWM + 1;
  // Interrupt status layout: matches first, then captures
  localparam int IR_CAP = NMATCH;
  localparam int IR_W = NMATCH + NCAP;
  localparam int SYNC_FOLLOW = 0;
  localparam logic [31:0] RESET_WORD = 32'h0;
endpackage : mbpwm_pkg

/* rtl/mbpwm_edge_sync.sv */
// Two-stage synchroniser with edge detect for the capture pins.
// Assumes asynchronous pin inputs and the timer's clock and enable.
`timescale 1ns/100ps
module mbpwm_edge_sync #(parameter int W = 2)
(
  input wire logic clk, // Timer clock
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] din, // Raw pin levels
  output logic [W-1:0] rise, // One-cycle rising pulse
  output logic [W-1:0] fall // One-cycle falling pulse
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  // Synchroniser chain plus one history stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end
    else if (ce)
    begin
      meta_r <= din;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edges seen only after the second stage
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule : mbpwm_edge_sync

/* rtl/mbpwm_top.sv */
// Match based PWM timer: prescaled counter, seven matches, captures,
// six modulated outputs, four match outputs and a Wishbone slave.
// Assumes classic Wishbone on CLK and asynchronous capture pins.
`timescale 1ns/100ps
module mbpwm_top
(
  input wire logic CLK, // Clock, 25 MHz
  input wire logic RST, // Synchronous reset, high
  input wire logic CE, // Clock enable, freezes all state
  input wire logic CYC_I, // Wishbone cycle
  input wire logic STB_I, // Wishbone strobe
  input wire logic WE_I, // Wishbone write
  input wire logic [mbpwm_pkg::AW-1:0] ADR_I, // Byte address
  input wire logic [mbpwm_pkg::SW-1:0] SEL_I, // Byte lanes
  input wire logic [mbpwm_pkg::DW-1:0] DAT_I, // Write data
  output logic [mbpwm_pkg::DW-1:0] DAT_O, // Read data
  output logic ACK_O, // Wishbone acknowledge
  input wire logic [mbpwm_pkg::NCAP-1:0] CAP_IN, // Capture pins
  input wire logic SYNC_IN, // Leader run level
  output logic SYNC_OUT, // Own enable level to follower
  output logic [mbpwm_pkg::NPWM:1] PWM_OUT, // Modulated outputs
  output logic [mbpwm_pkg::NEXT-1:0] MAT_OUT, // External match outputs
  output logic IRQ // Interrupt, high active
);
  import mbpwm_pkg::*;
  logic ack_r, req, wr, wr_tc, wr_tcr, wr_ler, wr_emr, wr_ir, sync_r;
  logic run, src, pc_tick, tc_tick, any_rst, any_stop;
  logic [DW-1:0] dat_o_r, rdat, wmask, wr_val, tc_r, pc_r, pr_r;
  logic [DW-1:0] mr_w_r [NMATCH], mr_a_r [NMATCH], cr_r [NCAP];
  logic [TCR_W-1:0] tcr_r;
  logic [MCR_BITS-1:0] mcr_r;
  logic [CCR_BITS-1:0] ccr_r;
  logic [CTCR_W-1:0] ctcr_r;
  logic [PCR_W-1:0] pcr_r;
  logic [EMR_W-1:0] emr_r;
  logic [NMATCH-1:0] ler_r, mhit, mint, mrst, mstop;
  logic [IR_W-1:0] ir_r, imr_r, ir_set, ir_clr;
  logic [NPWM:1] pwm_r, dbl, ena;
  logic [NCAP-1:0] cap_rise, cap_fall, cev, cint;

  // Address falls on a match register word
  function automatic logic mr_hit(input logic [AW-1:0] a);
    return (a >= OFF_MR0) && (a <= OFF_MR_LAST) && (a[1:0] == 2'h0);
  endfunction : mr_hit
  // Match register index from address
  function automatic logic [2:0] mr_idx(input logic [AW-1:0] a);
    logic [AW-1:0] d;
    d = a - OFF_MR0;
    return d[4:2];
  endfunction : mr_idx
  // Byte lanes to bit mask
  function automatic logic [DW-1:0] lane_mask(input logic [SW-1:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask
  // Bus decode; writes land on the edge that sees ACK high
  assign req = CYC_I & STB_I;
  assign wr = CE & req & WE_I & ack_r;
  assign wmask = lane_mask(SEL_I);
  assign wr_val = (rdat & ~wmask) | (DAT_I & wmask);
  assign wr_tc = wr && (ADR_I == OFF_TC);
  assign wr_tcr = wr && (ADR_I == OFF_TCR);
  assign wr_ler = wr && (ADR_I == OFF_LER);
  assign wr_emr = wr && (ADR_I == OFF_EMR);
  assign wr_ir = wr && (ADR_I == OFF_IR);

  // Read mux, unmapped and reserved bits read zero
  always_comb
  begin
    case (ADR_I)
      OFF_IR: rdat = 32'(ir_r);
      OFF_TCR: rdat = 32'(tcr_r);
      OFF_TC: rdat = tc_r;
      OFF_PR: rdat = pr_r;
      OFF_PC: rdat = pc_r;
      OFF_MCR: rdat = 32'(mcr_r);
      OFF_CCR: rdat = 32'(ccr_r);
      OFF_CR0: rdat = cr_r[0];
      OFF_CR1: rdat = cr_r[1];
      OFF_EMR: rdat = 32'(emr_r);
      OFF_CTCR: rdat = 32'(ctcr_r);
      OFF_PCR: rdat = 32'(pcr_r);
      OFF_LER: rdat = 32'(ler_r);
      OFF_IMR: rdat = 32'(imr_r);
      OFF_SYNC: rdat = 32'(sync_r);
      default: rdat = mr_hit(ADR_I) ? mr_w_r[mr_idx(ADR_I)] : RESET_WORD;
    endcase
  end

  // Acknowledge one cycle after the request, read data captured then
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ack_r <= 1'b0;
      dat_o_r <= RESET_WORD;
    end
    else if (CE)
    begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r)
        dat_o_r <= rdat;
    end
  end
  assign ACK_O = ack_r;
  assign DAT_O = dat_o_r;
  // Plain configuration registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pr_r <= RESET_WORD;
      mcr_r <= '0;
      ccr_r <= '0;
      ctcr_r <= '0;
      pcr_r <= '0;
      imr_r <= '0;
      sync_r <= 1'b0;
    end
    else if (wr)
    begin
      case (ADR_I)
        OFF_PR: pr_r <= wr_val;
        OFF_MCR: mcr_r <= wr_val[MCR_BITS-1:0];
        OFF_CCR: ccr_r <= wr_val[CCR_BITS-1:0];
        OFF_CTCR: ctcr_r <= wr_val[CTCR_W-1:0];
        OFF_PCR: pcr_r <= wr_val[PCR_W-1:0];
        OFF_IMR: imr_r <= wr_val[IR_W-1:0];
        OFF_SYNC: sync_r <= wr_val[SYNC_FOLLOW];
        default: ;
      endcase
    end
  end

  // Capture pins through the synchroniser
  mbpwm_edge_sync #(.W(NCAP)) u_cap_sync
  (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .din(CAP_IN),
    .rise(cap_rise),
    .fall(cap_fall)
  );
  // Count source: every clock or chosen capture edges
  always_comb
  begin
    case (ctcr_r[1:0])
      CNT_TIMER: src = 1'b1;
      CNT_RISE: src = cap_rise[ctcr_r[CTCR_SEL]];
      CNT_FALL: src = cap_fall[ctcr_r[CTCR_SEL]];
      CNT_BOTH: src = cap_rise[ctcr_r[CTCR_SEL]] | cap_fall[ctcr_r[CTCR_SEL]];
      default: src = 1'b0;
    endcase
  end

  // Follower runs only while the leader runs
  assign run = CE & tcr_r[TCR_EN] & ~tcr_r[TCR_RST] & (~sync_r | SYNC_IN);
  assign pc_tick = run & src;
  assign tc_tick = pc_tick & (pc_r == pr_r);
  assign SYNC_OUT = tcr_r[TCR_EN];

  // Per-match compare and action bits
  for (genvar i = 0; i < NMATCH; i++)
  begin : g_match
    assign mhit[i] = tc_tick & (tc_r == mr_a_r[i]);
    assign mint[i] = mcr_r[i * MCR_W + MCR_INT];
    assign mrst[i] = mcr_r[i * MCR_W + MCR_RST];
    assign mstop[i] = mcr_r[i * MCR_W + MCR_STOP];
  end
  assign any_rst = |(mhit & mrst);
  assign any_stop = |(mhit & mstop);
  // Timer control; a stop match clears enable, software write wins
  always_ff @(posedge CLK)
  begin
    if (RST)
      tcr_r <= '0;
    else if (wr_tcr)
      tcr_r <= wr_val[TCR_W-1:0];
    else if (CE && any_stop)
      tcr_r[TCR_EN] <= 1'b0;
  end

  // Prescaler and counter
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pc_r <= RESET_WORD;
      tc_r <= RESET_WORD;
    end
    else if (CE)
    begin
      if (tcr_r[TCR_RST])
        pc_r <= RESET_WORD;
      else if (pc_tick)
        pc_r <= tc_tick ? RESET_WORD : pc_r + 32'h1;
      if (wr_tc)
        tc_r <= wr_val;
      else if (tcr_r[TCR_RST])
        tc_r <= RESET_WORD;
      else if (tc_tick)
        tc_r <= any_rst ? RESET_WORD : tc_r + 32'h1;
    end
  end

  // Written match values
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NMATCH; i++)
        mr_w_r[i] <= RESET_WORD;
    end
    else if (wr && mr_hit(ADR_I))
      mr_w_r[mr_idx(ADR_I)] <= wr_val;
  end

  // Active match values: direct in timer use, released at cycle match
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NMATCH; i++)
        mr_a_r[i] <= RESET_WORD;
    end
    else if (CE)
    begin
      for (int i = 0; i < NMATCH; i++)
        if (!tcr_r[TCR_PWM])
          mr_a_r[i] <= mr_w_r[i];
        else if (mhit[0] && ler_r[i])
          mr_a_r[i] <= mr_w_r[i];
    end
  end

  // Release bits, consumed at the cycle boundary
  always_ff @(posedge CLK)
  begin
    if (RST)
      ler_r <= '0;
    else if (wr_ler)
      ler_r <= wr_val[NMATCH-1:0];
    else if (CE && tcr_r[TCR_PWM] && mhit[0])
      ler_r <= '0;
  end

  // External match outputs and their actions
  always_ff @(posedge CLK)
  begin
    if (RST)
      emr_r <= '0;
    else if (wr_emr)
      emr_r <= wr_val[EMR_W-1:0];
    else if (CE)
    begin
      for (int j = 0; j < NEXT; j++)
        if (mhit[j])
          case (emr_r[EMR_CTL + 2 * j +: 2])
            EM_LOW: emr_r[j] <= 1'b0;
            EM_HIGH: emr_r[j] <= 1'b1;
            EM_TOGGLE: emr_r[j] <= ~emr_r[j];
            default: ;
          endcase
    end
  end
  assign MAT_OUT = emr_r[NEXT-1:0];
  // Capture events per input
  for (genvar k = 0; k < NCAP; k++)
  begin : g_cap
    assign cev[k] = (cap_rise[k] & ccr_r[k * CCR_W + CCR_RISE])
                  | (cap_fall[k] & ccr_r[k * CCR_W + CCR_FALL]);
    assign cint[k] = ccr_r[k * CCR_W + CCR_INT];
  end

  // Capture registers latch the counter
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int k = 0; k < NCAP; k++)
        cr_r[k] <= RESET_WORD;
    end
    else if (CE)
    begin
      for (int k = 0; k < NCAP; k++)
        if (cev[k])
          cr_r[k] <= tc_r;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  assign ir_set = {cev & cint, mhit & mint};
  assign ir_clr = wr_ir ? (DAT_I[IR_W-1:0] & wmask[IR_W-1:0]) : '0;
  always_ff @(posedge CLK)
  begin
    if (RST)
      ir_r <= '0;
    else if (CE)
      ir_r <= (ir_r & ~ir_clr) | ir_set;
  end
  assign IRQ = |(ir_r & imr_r);
  // Output modes: double-edge select and per-output enable
  assign dbl = {pcr_r[NPWM:2], 1'b0};
  assign ena = pcr_r[PCR_ENA + NPWM:PCR_ENA + 1];

  // Modulated outputs; a clearing match beats a setting one
  always_ff @(posedge CLK)
  begin
    if (RST)
      pwm_r <= '0;
    else if (CE)
    begin
      for (int n = 1; n <= NPWM; n++)
        if (!tcr_r[TCR_PWM] || !ena[n])
          pwm_r[n] <= 1'b0;
        else if (mhit[n])
          pwm_r[n] <= 1'b0;
        else if (dbl[n] ? mhit[n-1] : mhit[0])
          pwm_r[n] <= 1'b1;
    end
  end
  assign PWM_OUT = pwm_r;
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  chk_cycle_wrap: assert property (
    any_rst && !wr_tc && !tcr_r[TCR_RST] |=> tc_r == 32'h0)
    else $error("counter did not wrap on reset match");
  chk_tc_step: assert property (
    tc_tick && !any_rst && !wr_tc && !tcr_r[TCR_RST]
    |=> tc_r == $past(tc_r) + 32'h1)
    else $error("counter did not advance on terminal count");
  chk_tc_hold: assert property (
    CE && !tc_tick && !wr_tc && !tcr_r[TCR_RST] |=> $stable(tc_r))
    else $error("counter moved without prescaler terminal count");
  chk_stop_match: assert property (
    CE && any_stop && !wr_tcr |=> !tcr_r[TCR_EN] && !tc_tick)
    else $error("stop match left the counter running");
  chk_match_irq: assert property (
    mhit[0] && mint[0] |=> ir_r[0] && (IRQ || !imr_r[0]))
    else $error("match interrupt flag not set");
  chk_single_rise: assert property (
    tcr_r[TCR_PWM] && ena[1] && mhit[0] && !mhit[1] |=> PWM_OUT[1])
    else $error("single-edge output did not rise at cycle start");
  chk_single_fall: assert property (
    tcr_r[TCR_PWM] && mhit[1] |=> !PWM_OUT[1])
    else $error("single-edge output did not fall at its match");
  chk_double_rise: assert property (
    tcr_r[TCR_PWM] && ena[2] && dbl[2] && mhit[1] && !mhit[2]
    |=> PWM_OUT[2])
    else $error("double-edge output did not rise at its match");
  chk_shadow_hold: assert property (
    CE && tcr_r[TCR_PWM] && !mhit[0] |=> $stable(mr_a_r[1]))
    else $error("match value changed inside a cycle");
  chk_capture_take: assert property (
    CE && cev[0] |=> cr_r[0] == $past(tc_r))
    else $error("capture did not latch the counter");
  chk_ext_toggle: assert property (
    mhit[0] && emr_r[EMR_CTL +: 2] == EM_TOGGLE && !wr_emr
    |=> MAT_OUT[0] != $past(MAT_OUT[0]))
    else $error("match output did not toggle");
  chk_timer_quiet: assert property (
    CE && !tcr_r[TCR_PWM] |=> PWM_OUT == '0)
    else $error("modulated output active in timer use");
  chk_follow_wait: assert property (
    sync_r && !SYNC_IN |-> !pc_tick)
    else $error("follower counted while leader stopped");
  cov_cycle_wrap: cover property (any_rst ##1 tc_tick);
  cov_release: cover property (tcr_r[TCR_PWM] && mhit[0] && |ler_r);
  cov_capture: cover property (|cev);
  cov_stop: cover property (any_stop);
endmodule : mbpwm_top

/* dv/mbpwm_load_model.sv */
// Load on one modulated pin: measures pulse high time and repetition.
// Assumes the pin is a registered level on the rising edge of clk.
`timescale 1ns/100ps
module mbpwm_load_model
(
  input wire logic clk, // Timer clock
  input wire logic pin, // Observed output level
  output logic [31:0] hi_len, // Cycles high in last pulse
  output logic [31:0] per_len // Cycles between last two rises
);
  logic last_r = 1'b0;
  logic [31:0] hi_cnt_r = 32'h0;
  logic [31:0] per_cnt_r = 32'h0;
  initial hi_len = 32'h0;
  initial per_len = 32'h0;
  // Count high cycles and the spacing of rising edges
  always @(posedge clk)
  begin
    last_r <= pin;
    per_cnt_r <= per_cnt_r + 32'h1;
    if (pin && !last_r)
    begin
      per_len <= per_cnt_r;
      per_cnt_r <= 32'h1;
      hi_cnt_r <= 32'h1;
    end
    else if (pin)
      hi_cnt_r <= hi_cnt_r + 32'h1;
    else if (last_r)
      hi_len <= hi_cnt_r;
  end
endmodule : mbpwm_load_model

/* dv/tb_top.sv */
// Self-checking bench for the match based PWM timer.
// Assumes a classic Wishbone slave answering one cycle after taking.
`timescale 1ns/100ps
module tb_top;
  import mbpwm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [AW-1:0] adr = '0;
  logic [DW-1:0] dwr = '0;
  logic [DW-1:0] q;
  logic [NCAP-1:0] cap = '0;
  logic [2:0] psel = 3'h0;
  logic ce = 1'b1;
  logic sync_in = 1'b0;
  logic [DW-1:0] dat_o;
  logic ack, sync_out, irq, probe;
  logic [NPWM:1] pwm;
  logic [NEXT-1:0] mat;
  logic [31:0] hi_len, per_len;
  logic [3:0] exp_mat;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  // 25 MHz clock
  always #20 clk = ~clk;
  mbpwm_top i_dut (.CLK(clk), .RST(rst), .CE(ce), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dwr),
    .DAT_O(dat_o), .ACK_O(ack), .CAP_IN(cap), .SYNC_IN(sync_in),
    .SYNC_OUT(sync_out), .PWM_OUT(pwm), .MAT_OUT(mat), .IRQ(irq));
  // Load watches one selected pin
  assign probe = (psel == 3'h0) ? mat[0] : pwm[psel];
  mbpwm_load_model i_load (.clk(clk), .pin(probe), .hi_len(hi_len),
    .per_len(per_len));
  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // A bounded wait that ran out ends the run
  task automatic guard(input int cnt);
    if (cnt >= 200)
    begin
      fail_count++;
      $display("[FAIL] %0t wait timed out", $time);
      print_verdict();
    end
  endtask : guard
  // One classic Wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 200);
    guard(k);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rdchk
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFF_TCR, 32'h0);
    rdchk(OFF_IR, 32'h0);
    rdchk(8'h60, 32'h0);
    wr(OFF_MR_LAST, 32'hdeadbeef);
    rdchk(OFF_MR_LAST, 32'hdeadbeef);
    wr(OFF_PC, 32'h5);
    rdchk(OFF_PC, 32'h0);
    $display("test registers done");
    // Prescaled counter, cycle reset, toggle output, interrupt
    wr(OFF_PR, 32'h2);
    wr(OFF_MR0, 32'h4);
    wr(OFF_MCR, 32'h3);
    wr(OFF_IMR, 32'h1);
    wr(OFF_EMR, 32'h30);
    wr(OFF_TCR, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    guard(n);
    repeat (80) @(posedge clk);
    check(per_len, 32'd30);
    check(hi_len, 32'd15);
    check(pwm, 6'h0);
    wr(OFF_TCR, 32'h0);
    bus(1'b0, OFF_IR, 32'h0);
    check(q[0], 1'b1);
    wr(OFF_IR, 32'h1ff);
    rdchk(OFF_IR, 32'h0);
    check(irq, 1'b0);
    $display("test timer done");
    // Stop on match with every output action
    exp_mat = 4'b0101;
    wr(OFF_MR0 + 8'h4, 32'h2);
    wr(OFF_MCR, 32'h20);
    for (int c = 0; c < 4; c++)
    begin
      wr(OFF_EMR, (c << 6) | 32'h2);
      wr(OFF_TC, 32'h0);
      wr(OFF_TCR, 32'h1);
      n = 0;
      while (sync_out !== 1'b0 && n < 200)
      begin
        @(posedge clk);
        n++;
      end
      guard(n);
      @(posedge clk);
      check(mat[1], exp_mat[c]);
    end
    rdchk(OFF_TCR, 32'h0);
    $display("test stop and actions done");
    // Capture latches a frozen count
    wr(OFF_TC, 32'h1234);
    wr(OFF_CCR, 32'h5);
    wr(OFF_IMR, 32'h80);
    wr(OFF_IR, 32'h1ff);
    @(posedge clk);
    cap <= 2'b01;
    repeat (6) @(posedge clk);
    rdchk(OFF_CR0, 32'h1234);
    check(irq, 1'b1);
    cap <= 2'b00;
    $display("test capture done");
    // Counter mode: rising edges of capture input 1 step the count
    wr(OFF_PR, 32'h0);
    wr(OFF_CTCR, 32'h5);
    wr(OFF_TC, 32'h0);
    wr(OFF_TCR, 32'h1);
    for (int e = 0; e < 3; e++)
    begin
      cap <= 2'b10;
      repeat (4) @(posedge clk);
      cap <= 2'b00;
      repeat (4) @(posedge clk);
    end
    rdchk(OFF_TC, 32'h3);
    wr(OFF_CTCR, 32'h0);
    $display("test counter mode done");
    // Follower holds until the leader's run level rises
    wr(OFF_SYNC, 32'h1);
    wr(OFF_TC, 32'h0);
    wr(OFF_TCR, 32'h1);
    repeat (10) @(posedge clk);
    rdchk(OFF_TC, 32'h0);
    sync_in <= 1'b1;
    repeat (20) @(posedge clk);
    rdchk(OFF_TC, 32'h3);
    check(sync_out, 1'b0);
    sync_in <= 1'b0;
    wr(OFF_SYNC, 32'h0);
    $display("test lockstep done");
    // Single edge output, release of new match values
    wr(OFF_TCR, 32'h2);
    wr(OFF_PR, 32'h0);
    wr(OFF_MCR, 32'h2);
    wr(OFF_MR0, 32'h9);
    wr(OFF_MR0 + 8'h4, 32'h3);
    wr(OFF_PCR, 32'h200);
    wr(OFF_LER, 32'h3);
    wr(OFF_TCR, 32'h9);
    psel <= 3'h1;
    repeat (40) @(posedge clk);
    check(per_len, 32'd10);
    check(hi_len, 32'd4);
    wr(OFF_MR0 + 8'h4, 32'h6);
    repeat (40) @(posedge clk);
    check(hi_len, 32'd4);
    wr(OFF_LER, 32'h2);
    repeat (40) @(posedge clk);
    check(hi_len, 32'd7);
    $display("test single edge done");
    // Double edge output, positive then negative pulse
    wr(OFF_PCR, 32'h604);
    wr(OFF_MR0 + 8'h8, 32'h8);
    wr(OFF_LER, 32'h4);
    psel <= 3'h2;
    repeat (40) @(posedge clk);
    check(hi_len, 32'd2);
    check(per_len, 32'd10);
    wr(OFF_MR0 + 8'h8, 32'h2);
    wr(OFF_LER, 32'h4);
    repeat (40) @(posedge clk);
    check(hi_len, 32'd6);
    wr(OFF_MR0 + 8'h4, 32'h9);
    wr(OFF_LER, 32'h2);
    repeat (30) @(posedge clk);
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk);
      check(pwm[1], 1'b0);
    end
    $display("test double edge done");
    // Clock enable low freezes the running outputs
    ce <= 1'b0;
    @(posedge clk);
    q = 32'(pwm);
    for (int k = 0; k < 20; k++)
    begin
      @(posedge clk);
      check(pwm, q);
    end
    ce <= 1'b1;
    $display("test clock enable done");
    print_verdict();
  end
endmodule : tb_top
